// ===== logic/epi_params.svh
`ifndef EPI_PARAMS_SVH
`define EPI_PARAMS_SVH

// register byte offsets
`define EPI_OFF_CONTROL   8'h00
`define EPI_OFF_MASK      8'h04
`define EPI_OFF_FLAG      8'h08
`define EPI_OFF_CHG_LOW   8'h0C
`define EPI_OFF_CHG_HIGH  8'h10

// field positions in interrupt_mask and interrupt_flag_reg
`define EPI_BIT_DED       6
`define EPI_BIT_GRP_HIGH  5
`define EPI_BIT_GRP_LOW   4

// vector program addresses
`define EPI_VEC_RESET     5'h00
`define EPI_VEC_DED       5'h01
`define EPI_VEC_GRP_LOW   5'h02
`define EPI_VEC_GRP_HIGH  5'h03
`define EPI_VEC_PERIPH    4
`define EPI_VEC_COUNT     17
`define EPI_PERIPH_COUNT  13

// pin groups and reset sources
`define EPI_LOW_PINS      8
`define EPI_HIGH_PINS     4
`define EPI_RESET_SRCS    4

// bus answers and reset values
`define EPI_RESP_OKAY     2'h0
`define EPI_RESP_SLVERR   2'h2
`define EPI_MASK_RESET    8'h00

`endif

// ===== logic/epi_pkg.sv
`default_nettype none
package epi_pkg;
  // trigger choice of the dedicated pin, in control-field order
  typedef enum logic [1:0] {SENSE_LOW, SENSE_ANY, SENSE_FALL, SENSE_RISE} epi_sense_type;
  // program address of a vector
  typedef logic [4:0] epi_vec_type;
endpackage
`default_nettype wire

// ===== logic/epi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module epi_sync #(
  parameter int WIDTH = 13
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  // two flops per pin; the first is seen only by the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      always_ff @(posedge mclk) begin
        if (reset) begin
          stage1     <= 1'b1;
          syncOut[i] <= 1'b1;
        end else begin
          stage1     <= asyncIn[i];
          syncOut[i] <= stage1;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== logic/epi_vector.sv
`timescale 1ns/1ps
`default_nettype none
module epi_vector #(
  parameter int NUM = 17
) (
  input  wire logic [NUM-1:0]    requests,
  output logic                   anyValid,
  output epi_pkg::epi_vec_type   winner
);
  import epi_pkg::*;
  // scan downward so the lowest address wins
  always_comb begin
    anyValid = 1'b0;
    winner   = '0;
    for (int i = NUM - 1; i >= 0; i--) begin
      if (requests[i]) begin
        anyValid = 1'b1;
        winner   = epi_vec_type'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/epi_top.sv
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "epi_params.svh"
`default_nettype none
module epi_top (
  input  wire logic                         mclk,
  input  wire logic                         reset,
  // AXI4-Lite slave
  input  wire logic [7:0]                   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [7:0]                   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // pins and core
  input  wire logic                         dedicatedIrqPin,
  input  wire logic [11:0]                  pinChangeInputs,
  input  wire logic                         ioClockRun,
  input  wire logic                         globalIntEnable,
  input  wire logic [3:0]                   resetSources,
  input  wire logic [12:0]                  periphIrq,
  input  wire logic                         coreAck,
  output logic                              irqRequest,
  output epi_pkg::epi_vec_type              irqVector,
  output logic                              wakeRequest
);
  import epi_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ****************************************
  // register state
  // ****************************************
  epi_sense_type        senseMode;
  logic [2:0]           groupEnable;
  logic [7:0]           changeMaskLow;
  logic [3:0]           changeMaskHigh;
  logic                 dedFlag;
  logic                 grpLowFlag;
  logic                 grpHighFlag;

  // ****************************************
  // bus slave
  // ****************************************
  logic                 awHeld;
  logic                 wHeld;
  logic [7:0]           wAddr;
  logic [31:0]          wData;
  logic                 wByte0;
  wire                  writeFire = awHeld && wHeld && !s_axi_bvalid;
  wire  [7:0]           wAlign    = {wAddr[7:2], 2'b00};
  wire                  wrEn      = writeFire && wByte0;
  wire                  wrCtl     = wrEn && (wAlign == `EPI_OFF_CONTROL);
  wire                  wrMask    = wrEn && (wAlign == `EPI_OFF_MASK);
  wire                  wrFlag    = wrEn && (wAlign == `EPI_OFF_FLAG);
  wire                  wrChgLow  = wrEn && (wAlign == `EPI_OFF_CHG_LOW);
  wire                  wrChgHigh = wrEn && (wAlign == `EPI_OFF_CHG_HIGH);
  wire                  wrHit     = (wAlign == `EPI_OFF_CONTROL) || (wAlign == `EPI_OFF_MASK) ||
                                    (wAlign == `EPI_OFF_FLAG) || (wAlign == `EPI_OFF_CHG_LOW) ||
                                    (wAlign == `EPI_OFF_CHG_HIGH);

  // ready drops while a word waits, so each channel holds at most one
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // write capture, either channel first
  always_ff @(posedge mclk) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      wAddr  <= 8'h00;
      wData  <= 32'h0000_0000;
      wByte0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        wAddr  <= s_axi_awaddr;
      end else if (writeFire) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld  <= 1'b1;
        wData  <= s_axi_wdata;
        wByte0 <= s_axi_wstrb[0];
      end else if (writeFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer an error
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EPI_RESP_OKAY;
    end else if (writeFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? `EPI_RESP_OKAY : `EPI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // readback; reserved bits stay zero
  logic [7:0]           maskRead;
  logic [7:0]           flagRead;
  always_comb begin
    maskRead = 8'h00;
    flagRead = 8'h00;
    maskRead[`EPI_BIT_DED]      = groupEnable[2];
    maskRead[`EPI_BIT_GRP_HIGH] = groupEnable[1];
    maskRead[`EPI_BIT_GRP_LOW]  = groupEnable[0];
    flagRead[`EPI_BIT_DED]      = dedFlag && (senseMode != SENSE_LOW);
    flagRead[`EPI_BIT_GRP_HIGH] = grpHighFlag;
    flagRead[`EPI_BIT_GRP_LOW]  = grpLowFlag;
  end

  wire  [7:0]           rAlign = {s_axi_araddr[7:2], 2'b00};
  wire                  rHit   = (rAlign == `EPI_OFF_CONTROL) || (rAlign == `EPI_OFF_MASK) ||
                                 (rAlign == `EPI_OFF_FLAG) || (rAlign == `EPI_OFF_CHG_LOW) ||
                                 (rAlign == `EPI_OFF_CHG_HIGH);
  wire  [7:0]           rByte  = (rAlign == `EPI_OFF_CONTROL)  ? {6'h00, senseMode} :
                                 (rAlign == `EPI_OFF_MASK)     ? maskRead :
                                 (rAlign == `EPI_OFF_FLAG)     ? flagRead :
                                 (rAlign == `EPI_OFF_CHG_LOW)  ? changeMaskLow :
                                 (rAlign == `EPI_OFF_CHG_HIGH) ? {4'h0, changeMaskHigh} : 8'h00;

  // read answer one cycle after the address is taken
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `EPI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rByte};
      s_axi_rresp  <= rHit ? `EPI_RESP_OKAY : `EPI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      senseMode      <= SENSE_LOW;
      groupEnable    <= 3'h0;
      changeMaskLow  <= `EPI_MASK_RESET;
      changeMaskHigh <= 4'h0;
    end else begin
      if (wrCtl)
        senseMode <= epi_sense_type'(wData[1:0]);
      if (wrMask)
        groupEnable <= {wData[`EPI_BIT_DED], wData[`EPI_BIT_GRP_HIGH], wData[`EPI_BIT_GRP_LOW]};
      if (wrChgLow)
        changeMaskLow <= wData[7:0];
      if (wrChgHigh)
        changeMaskHigh <= wData[3:0];
    end
  end

  // ****************************************
  // pin sampling and detection
  // ****************************************
  // raw levels are taken whatever the pin direction, so firmware may drive them
  wire  [12:0]          pinRaw = {dedicatedIrqPin, pinChangeInputs};
  logic [12:0]          pinSync;
  logic [12:0]          pinPrev;

  epi_sync #(.WIDTH(13)) u_sync (
    .mclk    (mclk),
    .reset   (reset),
    .asyncIn (pinRaw),
    .syncOut (pinSync)
  );

  // previous sample for edge and toggle compare
  always_ff @(posedge mclk) begin
    if (reset)
      pinPrev <= 13'h1FFF;
    else
      pinPrev <= pinSync;
  end

  wire  [11:0]          toggled = pinSync[11:0] ^ pinPrev[11:0];
  wire                  lowHit  = |(toggled[7:0] & changeMaskLow);
  wire                  highHit = |(toggled[11:8] & changeMaskHigh);
  wire                  dedRise = pinSync[12] && !pinPrev[12];
  wire                  dedFall = !pinSync[12] && pinPrev[12];
  // a stopped I/O clock blinds the edge detector
  wire                  dedHit  = ioClockRun && ((senseMode == SENSE_ANY  && (dedRise || dedFall)) ||
                                                 (senseMode == SENSE_FALL && dedFall) ||
                                                 (senseMode == SENSE_RISE && dedRise));

  // clockless wake path straight from the pins; not a request itself
  assign wakeRequest = (groupEnable[2] && senseMode == SENSE_LOW && !dedicatedIrqPin) ||
                       (groupEnable[0] && |((pinRaw[7:0] ^ pinPrev[7:0]) & changeMaskLow)) ||
                       (groupEnable[1] && |((pinRaw[11:8] ^ pinPrev[11:8]) & changeMaskHigh));

  // ****************************************
  // flags
  // ****************************************
  // a trigger in the clearing cycle wins over the clear
  wire                  clrDed  = (wrFlag && wData[`EPI_BIT_DED]) || (coreAck && irqVector == `EPI_VEC_DED);
  wire                  clrLow  = (wrFlag && wData[`EPI_BIT_GRP_LOW]) ||
                                  (coreAck && irqVector == `EPI_VEC_GRP_LOW);
  wire                  clrHigh = (wrFlag && wData[`EPI_BIT_GRP_HIGH]) ||
                                  (coreAck && irqVector == `EPI_VEC_GRP_HIGH);
  wire                  next_dedFlag  = (senseMode != SENSE_LOW) && (dedHit || (dedFlag && !clrDed));
  wire                  next_lowFlag  = lowHit || (grpLowFlag && !clrLow);
  wire                  next_highFlag = highHit || (grpHighFlag && !clrHigh);

  always_ff @(posedge mclk) begin
    if (reset) begin
      dedFlag     <= 1'b0;
      grpLowFlag  <= 1'b0;
      grpHighFlag <= 1'b0;
    end else begin
      dedFlag     <= next_dedFlag;
      grpLowFlag  <= next_lowFlag;
      grpHighFlag <= next_highFlag;
    end
  end

  // ****************************************
  // vector selection
  // ****************************************
  // level mode requests from the live level, so a level that left early raises nothing
  wire                  dedPending = (senseMode == SENSE_LOW) ? !pinSync[12] : dedFlag;
  wire  [16:0]          requests;
  assign requests[`EPI_VEC_RESET]    = |resetSources;
  assign requests[`EPI_VEC_DED]      = globalIntEnable && groupEnable[2] && dedPending;
  assign requests[`EPI_VEC_GRP_LOW]  = globalIntEnable && groupEnable[0] && grpLowFlag;
  assign requests[`EPI_VEC_GRP_HIGH] = globalIntEnable && groupEnable[1] && grpHighFlag;
  assign requests[16:`EPI_VEC_PERIPH] = {`EPI_PERIPH_COUNT{globalIntEnable}} & periphIrq;

  logic                 anyReq;
  epi_vec_type          winner;

  epi_vector #(.NUM(`EPI_VEC_COUNT)) u_vector (
    .requests (requests),
    .anyValid (anyReq),
    .winner   (winner)
  );

  // registered request toward the core
  always_ff @(posedge mclk) begin
    if (reset) begin
      irqRequest <= 1'b0;
      irqVector  <= `EPI_VEC_RESET;
    end else begin
      irqRequest <= anyReq;
      irqVector  <= winner;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_resetVec;
    (|resetSources) |=> irqRequest && irqVector == `EPI_VEC_RESET;
  endproperty
  a_resetVec: assert property (p_resetVec) else $error("reset source did not select vector zero");

  property p_levelHold;
    (senseMode == SENSE_LOW && groupEnable[2] && globalIntEnable && !pinSync[12] && resetSources == 4'h0)
      |=> irqRequest && irqVector == `EPI_VEC_DED;
  endproperty
  a_levelHold: assert property (p_levelHold) else $error("low level did not request");

  property p_noGlobal;
    (!globalIntEnable && resetSources == 4'h0) |=> !irqRequest;
  endproperty
  a_noGlobal: assert property (p_noGlobal) else $error("request without global enable");

  property p_riseCatch;
    (senseMode == SENSE_RISE && ioClockRun && !pinPrev[12] && pinSync[12] && !wrMask && !wrCtl)
      |=> dedFlag;
  endproperty
  a_riseCatch: assert property (p_riseCatch) else $error("rising edge not flagged");

  property p_asleep;
    (senseMode inside {SENSE_FALL, SENSE_RISE} && !ioClockRun && !dedFlag && !wrCtl) |=> !dedFlag;
  endproperty
  a_asleep: assert property (p_asleep) else $error("edge flagged with I/O clock stopped");

  property p_levelFlag;
    (senseMode == SENSE_LOW) |=> !dedFlag || $past(wrCtl);
  endproperty
  a_levelFlag: assert property (p_levelFlag) else $error("flag set in level mode");

  property p_groupLow;
    lowHit |=> grpLowFlag;
  endproperty
  a_groupLow: assert property (p_groupLow) else $error("group low toggle lost");

  property p_maskOff;
    (changeMaskHigh == 4'h0 && !grpHighFlag && !wrChgHigh) |=> !grpHighFlag;
  endproperty
  a_maskOff: assert property (p_maskOff) else $error("masked pin set group high flag");

  property p_w1c;
    (wrFlag && wData[`EPI_BIT_GRP_LOW] && !lowHit) |=> !grpLowFlag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write of one did not clear flag");

  property p_priority;
    (requests[`EPI_VEC_DED] && requests[`EPI_VEC_GRP_LOW] && !requests[`EPI_VEC_RESET])
      |=> irqVector == `EPI_VEC_DED;
  endproperty
  a_priority: assert property (p_priority) else $error("lower address not served first");

  property p_bresp;
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");
endmodule
`default_nettype wire

// ===== dv/epi_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// *****
// far side: outside pin sources and the core's vector entry
// *****
module epi_pins_model (
  input  wire logic        mclk,
  input  wire logic        irqRequest,
  output logic             dedicatedIrqPin,
  output logic [11:0]      pinChangeInputs,
  output logic             coreAck
);
  // pins idle high, like the synchroniser reset, so no false change at start
  initial begin
    dedicatedIrqPin = 1'b1;
    pinChangeInputs = 12'hFFF;
    coreAck = 1'b0;
  end

  // new levels right after an edge, then held well over one clock period
  task automatic setPins(input logic ded, input logic [11:0] chg);
    @(posedge mclk);
    dedicatedIrqPin <= ded;
    pinChangeInputs <= chg;
    repeat (2) @(posedge mclk);
  endtask

  // core entry: one-cycle acknowledge, only while a request is offered
  task automatic ackOnce;
    @(posedge mclk);
    while (irqRequest !== 1'b1) @(posedge mclk);
    coreAck <= 1'b1;
    @(posedge mclk);
    coreAck <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/epi_top_tb.sv
`timescale 1ns/1ps
`include "epi_params.svh"
`default_nettype none
module epi_top_tb;
  import epi_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] resp;} epi_row_type;
  logic        mclk, reset, ioClockRun, globalIntEnable, coreAck, irqRequest, wakeRequest, dedicatedIrqPin;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, resetSources;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] pinChangeInputs;
  logic [12:0] periphIrq;
  epi_vec_type irqVector;
  int          errTotal, checked;
  // register rows: address, written word, word read back, response
  epi_row_type rows [6] = '{
    '{`EPI_OFF_CONTROL, 32'h02, 32'h02, `EPI_RESP_OKAY},
    '{`EPI_OFF_MASK, 32'hFF, 32'h70, `EPI_RESP_OKAY},
    '{`EPI_OFF_CHG_LOW, 32'hA5, 32'hA5, `EPI_RESP_OKAY},
    '{`EPI_OFF_CHG_HIGH, 32'hFF, 32'h0F, `EPI_RESP_OKAY},
    '{`EPI_OFF_FLAG, 32'hFF, 32'h00, `EPI_RESP_OKAY},
    '{8'h14, 32'h5A, 32'h00, `EPI_RESP_SLVERR}};

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  epi_top i_epi_top (.mclk(mclk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .dedicatedIrqPin(dedicatedIrqPin),
    .pinChangeInputs(pinChangeInputs), .ioClockRun(ioClockRun), .globalIntEnable(globalIntEnable),
    .resetSources(resetSources), .periphIrq(periphIrq), .coreAck(coreAck), .irqRequest(irqRequest),
    .irqVector(irqVector), .wakeRequest(wakeRequest));

  epi_pins_model i_epi_pins_model (.mclk(mclk), .irqRequest(irqRequest), .dedicatedIrqPin(dedicatedIrqPin),
    .pinChangeInputs(pinChangeInputs), .coreAck(coreAck));

  // *****
  // shared tasks
  // *****
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (errTotal == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // starts one edge late so a strobe is never driven twice in one step
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(a, d, r);
    check("rdata", d, exp);
  endtask

  // bounded wait for the expected vector to be offered
  task automatic expectIrq(input epi_vec_type v);
    int n;
    n = 0;
    @(posedge mclk);
    while (!(irqRequest === 1'b1 && irqVector === v) && n < 12) begin
      @(posedge mclk);
      n++;
    end
    // vector zero is also shown when idle, so the request must be seen with it
    check("irqVector", {26'h0, irqRequest, irqVector}, {26'h0, 1'b1, v});
  endtask

  // pipeline settles first, then no request may appear for eight cycles
  task automatic expectQuiet;
    logic seen;
    seen = 1'b0;
    repeat (3) @(posedge mclk);
    repeat (8) begin
      @(posedge mclk);
      seen = seen | irqRequest;
    end
    check("irqRequest", {31'h0, seen}, 32'h0);
  endtask

  // *****
  // main sequence
  // *****
  initial begin
    reset = 1'b1;
    ioClockRun = 1'b1;
    globalIntEnable = 1'b0;
    resetSources = 4'h0;
    periphIrq = 13'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      axiWrite(rows[i].a, rows[i].w, rsp);
      check("bresp", {30'h0, rsp}, {30'h0, rows[i].resp});
      axiRead(rows[i].a, rd, rsp);
      check("rdata", rd, rows[i].r);
      check("rresp", {30'h0, rsp}, {30'h0, rows[i].resp});
    end
    // second reset in mid-run clears every register
    reset <= 1'b1;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    foreach (rows[i]) rdChk(rows[i].a, 32'h0);
    // a word without byte lane 0 is answered but changes nothing
    s_axi_wstrb <= 4'hE;
    axiWrite(`EPI_OFF_CHG_LOW, 32'hFF, rsp);
    s_axi_wstrb <= 4'hF;
    check("bresp", {30'h0, rsp}, {30'h0, `EPI_RESP_OKAY});
    rdChk(`EPI_OFF_CHG_LOW, 32'h0);
    // peripheral vectors, then reset sources outrank them
    globalIntEnable <= 1'b1;
    for (int i = 0; i < `EPI_PERIPH_COUNT; i++) begin
      periphIrq <= 13'h1 << i;
      expectIrq(5'(`EPI_VEC_PERIPH + i));
    end
    for (int j = 0; j < `EPI_RESET_SRCS; j++) begin
      resetSources <= 4'h1 << j;
      expectIrq(`EPI_VEC_RESET);
    end
    resetSources <= 4'h0;
    periphIrq <= 13'h0;
    expectQuiet;
    // group low: masked pin 3 raises, ack clears, unmasked pin 2 is ignored
    axiWrite(`EPI_OFF_CHG_LOW, 32'h08, rsp);
    axiWrite(`EPI_OFF_MASK, 32'h10, rsp);
    i_epi_pins_model.setPins(1'b1, 12'hFF7);
    expectIrq(`EPI_VEC_GRP_LOW);
    rdChk(`EPI_OFF_FLAG, 32'h10);
    i_epi_pins_model.ackOnce;
    expectQuiet;
    rdChk(`EPI_OFF_FLAG, 32'h00);
    i_epi_pins_model.setPins(1'b1, 12'hFF3);
    expectQuiet;
    // group high: pin 9, cleared by write of one, then group disabled
    axiWrite(`EPI_OFF_CHG_HIGH, 32'h02, rsp);
    axiWrite(`EPI_OFF_MASK, 32'h30, rsp);
    i_epi_pins_model.setPins(1'b1, 12'hDF3);
    expectIrq(`EPI_VEC_GRP_HIGH);
    axiWrite(`EPI_OFF_FLAG, 32'h20, rsp);
    expectQuiet;
    axiWrite(`EPI_OFF_MASK, 32'h00, rsp);
    i_epi_pins_model.setPins(1'b1, 12'hFF3);
    expectQuiet;
    rdChk(`EPI_OFF_FLAG, 32'h20);
    axiWrite(`EPI_OFF_FLAG, 32'h20, rsp);
    // dedicated pin: each edge code against a fall and a rise
    axiWrite(`EPI_OFF_MASK, 32'h40, rsp);
    for (int c = 1; c < 4; c++) begin
      axiWrite(`EPI_OFF_CONTROL, 32'(c), rsp);
      for (int e = 0; e < 2; e++) begin
        i_epi_pins_model.setPins(1'(e), 12'hFF3);
        if ((e == 0) ? (c != 3) : (c != 2)) begin
          expectIrq(`EPI_VEC_DED);
          axiWrite(`EPI_OFF_FLAG, 32'h40, rsp);
        end
        expectQuiet;
      end
    end
    // stopped I/O clock hides a falling edge that would otherwise flag
    axiWrite(`EPI_OFF_CONTROL, 32'h02, rsp);
    ioClockRun <= 1'b0;
    i_epi_pins_model.setPins(1'b0, 12'hFF3);
    expectQuiet;
    // low level: masked by global flag, flag reads zero, request while low
    globalIntEnable <= 1'b0;
    axiWrite(`EPI_OFF_CONTROL, 32'h00, rsp);
    ioClockRun <= 1'b1;
    expectQuiet;
    rdChk(`EPI_OFF_FLAG, 32'h00);
    globalIntEnable <= 1'b1;
    expectIrq(`EPI_VEC_DED);
    check("wakeRequest", {31'h0, wakeRequest}, 32'h1);
    // the level is held until the request has been seen for a while
    repeat (4) @(posedge mclk);
    check("irqRequest", {31'h0, irqRequest}, 32'h1);
    i_epi_pins_model.setPins(1'b1, 12'hFF3);
    expectQuiet;
    give_verdict;
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge mclk);
    errTotal++;
    give_verdict;
  end
endmodule
`default_nettype wire
